// File: common/pwmas_pkg.sv
// shared constants and types for the pwm auto-shutdown block
package pwmas_pkg;

	////////////////////////////////////////////////////////////////////////////
	// apb register byte addresses
	localparam logic [7:0] ADDR_SHUTDOWN = 8'h00;
	localparam logic [7:0] ADDR_RESTART = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_PERIOD = 8'h0C;
	localparam logic [7:0] ADDR_DUTY = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int SD_FLAG_BIT = 7;
	localparam int RESTART_EN_BIT = 7;
	localparam int MODE_LO = 0;
	localparam int MODE_HI = 3;
	localparam int PRESCALE_LO = 4;
	localparam int PRESCALE_HI = 5;
	localparam int TIMER_RUN_BIT = 6;
	localparam int DIR_LO = 8;
	localparam int DIR_HI = 11;
	localparam int ST_TFLAG_BIT = 0;
	localparam int POL_AC_BIT = 1;
	localparam int POL_BD_BIT = 0;
	localparam int LVL_TRI_BIT = 1;
	localparam int LVL_HIGH_BIT = 0;
	localparam int SRC_C1_BIT = 0;
	localparam int SRC_C2_BIT = 1;
	localparam int SRC_FLT_BIT = 2;

	////////////////////////////////////////////////////////////////////////////
	// reset values and codes
	localparam logic [7:0] SD_RESET = 8'h00;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam logic [1:0] MODE_PWM_CODE = 2'h3;
	localparam logic [7:0] PERIOD_RESET = 8'hFF;
	localparam logic [7:0] DUTY_RESET = 8'h00;
	localparam logic [3:0] PRE_DIV1 = 4'h0;
	localparam logic [3:0] PRE_DIV4 = 4'h3;
	localparam logic [3:0] PRE_DIV16 = 4'hF;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// trigger selection, one bit per source
	typedef enum logic [2:0] {
		SRC_NONE = 3'b000,
		SRC_C1 = 3'b001,
		SRC_C2 = 3'b010,
		SRC_C1_C2 = 3'b011,
		SRC_FLT = 3'b100,
		SRC_FLT_C1 = 3'b101,
		SRC_FLT_C2 = 3'b110,
		SRC_ALL = 3'b111
	} pwmas_src_type;

	// shutdown control register layout
	typedef struct packed {
		logic flag;
		pwmas_src_type src;
		logic [1:0] lvl_ac;
		logic [1:0] lvl_bd;
	} pwmas_sdctl_type;

	// one pin pair: level and enable of each pin
	typedef struct packed {
		logic p;
		logic p_oe;
		logic s;
		logic s_oe;
	} pwmas_pair_type;

	// prescale code to last count of the divider
	function automatic logic [3:0] pwmas_pre_last(input logic [1:0] code);
		if (code[1])
			return PRE_DIV16;
		else if (code[0])
			return PRE_DIV4;
		else
			return PRE_DIV1;
	endfunction : pwmas_pre_last

endpackage : pwmas_pkg

// File: rtl/pwmas_pair_stage.sv
`timescale 1ns/1ps
`default_nettype none
module pwmas_pair_stage
	import pwmas_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// control
	input wire logic freeze,
	input wire logic pwm_raw,
	input wire logic active_low,
	input wire logic shut,
	input wire logic [1:0] level,
	input wire logic [1:0] dir_en,
	// pins
	output pwmas_pair_type pins_q
);

	pwmas_pair_type pins_d;

	////////////////////////////////////////////////////////////////////////////
	// shutdown overrides both pins; tri-state level drops the enables
	always_comb
	begin
		pins_d = pins_q;
		if (!freeze)
		begin
			pins_d.p = shut ? level[LVL_HIGH_BIT] : (pwm_raw ^ active_low);
			pins_d.s = pins_d.p;
			pins_d.p_oe = dir_en[0] & ~(shut & level[LVL_TRI_BIT]);
			pins_d.s_oe = dir_en[1] & ~(shut & level[LVL_TRI_BIT]);
		end
	end

	// reset leaves both pins undriven
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			pins_q <= '0;
		else
			pins_q <= pins_d;
	end

endmodule : pwmas_pair_stage
`default_nettype wire

// File: rtl/pwmas_top.sv
//Behaviour
//- flag in bit seven marks shutdown
//- three-bit field selects shutdown trigger sources
//- pair A/C shutdown level: tri, high, low
//- pair B/D shutdown level: tri, high, low
//- auto-restart clears flag when cause ends
//- without auto-restart firmware clears the flag
//- outputs resume only at next period start
//- flag writes ignored while cause active
//- comparator causes are levels, block clearing
//- writing one forces shutdown like hardware
//- mode low bits pick polarity per pair
//- period flag set as next period begins
//- pins undriven after reset until enabled
//- sleep freezes timer, state and pins
//- low-power run modes tick timer by pulse
//- low fault pin counts as a cause
//- shutdown reaches pins without period wait
//- flag at period start holds whole period
//- any selected source sets the flag
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pwmas_top
	import pwmas_pkg::*;
#(
	parameter int TIMER_W = 8
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// shutdown sources
	input wire logic fault_input_n,
	input wire logic comp1_out,
	input wire logic comp2_out,
	// power modes
	input wire logic sleep_mode,
	input wire logic low_power_run,
	input wire logic low_power_tick,
	// pwm pins
	output logic pwm_out_a,
	output logic pwm_out_a_oe,
	output logic pwm_out_b,
	output logic pwm_out_b_oe,
	output logic pwm_out_c,
	output logic pwm_out_c_oe,
	output logic pwm_out_d,
	output logic pwm_out_d_oe
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	pwmas_sdctl_type sd_q, sd_d;
	logic hw_set_q, hw_set_d;
	logic hold_q, hold_d;
	logic restart_q, restart_d;
	logic [11:0] mode_q, mode_d;
	logic [TIMER_W-1:0] period_q, period_d, duty_q, duty_d;
	logic [TIMER_W-1:0] timer_q, timer_d;
	logic [3:0] pre_q, pre_d;
	logic tflag_q, tflag_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic wr_fire, cause, sw_flag_wr, time_en, tick, period_start, pwm_raw, pwm_mode;
	logic [TIMER_W-1:0] timer_next;
	logic [7:0] sd_wr;
	pwmas_pair_type pair_ac, pair_bd;

	////////////////////////////////////////////////////////////////////////////
	// apb: one wait cycle, write lands at the pready edge
	assign wr_fire = psel & penable & pready_q & pwrite;
	assign sw_flag_wr = wr_fire && (paddr == ADDR_SHUTDOWN);
	assign sd_wr = pwdata[7:0];

	always_comb
	begin
		pready_d = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d = prdata_q;
		if (psel && penable && !pready_q)
		begin
			prdata_d = RDATA_ZERO;
			if (paddr == ADDR_SHUTDOWN)
				prdata_d[7:0] = sd_q;
			else if (paddr == ADDR_RESTART)
				prdata_d[RESTART_EN_BIT] = restart_q;
			else if (paddr == ADDR_MODE)
				prdata_d[DIR_HI:MODE_LO] = mode_q;
			else if (paddr == ADDR_PERIOD)
				prdata_d[TIMER_W-1:0] = period_q;
			else if (paddr == ADDR_DUTY)
				prdata_d[TIMER_W-1:0] = duty_q;
			else if (paddr == ADDR_STATUS)
				prdata_d = {16'h0000, 8'(timer_q), 2'b00, comp2_out, comp1_out, fault_input_n,
					hold_q, cause, tflag_q};
			else
				pslverr_d = 1'b1; // unmapped: error, reads zero
		end
	end

	// configuration registers other than the flag
	always_comb
	begin
		restart_d = restart_q;
		mode_d = mode_q;
		period_d = period_q;
		duty_d = duty_q;
		if (wr_fire && paddr == ADDR_RESTART)
			restart_d = pwdata[RESTART_EN_BIT];
		else if (wr_fire && paddr == ADDR_MODE)
			mode_d = pwdata[DIR_HI:MODE_LO];
		else if (wr_fire && paddr == ADDR_PERIOD)
			period_d = pwdata[TIMER_W-1:0];
		else if (wr_fire && paddr == ADDR_DUTY)
			duty_d = pwdata[TIMER_W-1:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// shutdown cause: comparators high or fault pin low, as selected
	always_comb
	begin
		cause = (sd_q.src[SRC_FLT_BIT] & ~fault_input_n)
			| (sd_q.src[SRC_C1_BIT] & comp1_out)
			| (sd_q.src[SRC_C2_BIT] & comp2_out);
	end

	// flag: hardware set wins over any write, so a live cause cannot be cleared
	always_comb
	begin
		sd_d = sd_q;
		hw_set_d = hw_set_q;
		if (wr_fire && paddr == ADDR_SHUTDOWN)
		begin
			sd_d.src = pwmas_src_type'(sd_wr[6:4]);
			sd_d.lvl_ac = sd_wr[3:2];
			sd_d.lvl_bd = sd_wr[1:0];
		end
		if (sleep_mode)
		begin
			sd_d.flag = sd_q.flag;
		end
		else if (cause)
		begin
			sd_d.flag = 1'b1;
			hw_set_d = 1'b1;
		end
		else if (sw_flag_wr)
		begin
			sd_d.flag = sd_wr[SD_FLAG_BIT];
			hw_set_d = 1'b0; // a forced shutdown waits for firmware
		end
		else if (restart_q && hw_set_q && sd_q.flag)
		begin
			sd_d.flag = 1'b0;
			hw_set_d = 1'b0;
		end
	end

	// output hold: enters at once, leaves only at a period boundary
	always_comb
	begin
		hold_d = hold_q;
		if (sleep_mode)
			hold_d = hold_q;
		else if (sd_q.flag || cause)
			hold_d = 1'b1;
		else if (period_start)
			hold_d = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// time base: prescaler then period counter
	assign time_en = mode_q[TIMER_RUN_BIT] & ~sleep_mode & (~low_power_run | low_power_tick);
	assign tick = time_en && (pre_q == pwmas_pre_last(mode_q[PRESCALE_HI:PRESCALE_LO]));
	assign period_start = tick && (timer_q == period_q);
	assign timer_next = timer_q + 1'b1;

	always_comb
	begin
		pre_d = pre_q;
		timer_d = timer_q;
		tflag_d = tflag_q;
		if (tick)
			pre_d = '0;
		else if (time_en)
			pre_d = pre_q + 4'h1;
		if (period_start)
			timer_d = '0;
		else if (tick)
			timer_d = timer_next;
		if (wr_fire && paddr == ADDR_STATUS && pwdata[ST_TFLAG_BIT])
			tflag_d = 1'b0;
		if (period_start)
			tflag_d = 1'b1;
	end

	// raw waveform only in pwm mode
	assign pwm_mode = (mode_q[MODE_HI:MODE_HI-1] == MODE_PWM_CODE);
	assign pwm_raw = pwm_mode & (timer_q < duty_q);

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			sd_q <= SD_RESET;
			hw_set_q <= 1'b0;
			hold_q <= 1'b0;
			restart_q <= 1'b0;
			mode_q <= {8'h00, MODE_RESET};
			period_q <= PERIOD_RESET;
			duty_q <= DUTY_RESET;
			timer_q <= '0;
			pre_q <= '0;
			tflag_q <= 1'b0;
			prdata_q <= RDATA_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			sd_q <= sd_d;
			hw_set_q <= hw_set_d;
			hold_q <= hold_d;
			restart_q <= restart_d;
			mode_q <= mode_d;
			period_q <= period_d;
			duty_q <= duty_d;
			timer_q <= timer_d;
			pre_q <= pre_d;
			tflag_q <= tflag_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin stages fed from hold_d, so shutdown lands one edge after the cause
	pwmas_pair_stage u_pair_ac (
		.clock(clock),
		.rst_n(rst_n),
		.freeze(sleep_mode),
		.pwm_raw(pwm_raw),
		.active_low(mode_q[POL_AC_BIT]),
		.shut(hold_d),
		.level(sd_q.lvl_ac),
		.dir_en(mode_q[DIR_LO+1:DIR_LO]),
		.pins_q(pair_ac)
	);

	pwmas_pair_stage u_pair_bd (
		.clock(clock),
		.rst_n(rst_n),
		.freeze(sleep_mode),
		.pwm_raw(pwm_raw),
		.active_low(mode_q[POL_BD_BIT]),
		.shut(hold_d),
		.level(sd_q.lvl_bd),
		.dir_en(mode_q[DIR_HI:DIR_HI-1]),
		.pins_q(pair_bd)
	);

	assign pwm_out_a = pair_ac.p;
	assign pwm_out_a_oe = pair_ac.p_oe;
	assign pwm_out_c = pair_ac.s;
	assign pwm_out_c_oe = pair_ac.s_oe;
	assign pwm_out_b = pair_bd.p;
	assign pwm_out_b_oe = pair_bd.p_oe;
	assign pwm_out_d = pair_bd.s;
	assign pwm_out_d_oe = pair_bd.s_oe;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_src_sets_flag: assert property (cause && !sleep_mode |=> sd_q.flag)
		else $error("selected cause did not set flag");
	a_cause_blocks_clear: assert property (cause && !sleep_mode && sw_flag_wr |=> sd_q.flag)
		else $error("flag cleared during active cause");
	a_auto_restart: assert property (restart_q && hw_set_q && sd_q.flag && !cause && !sleep_mode
		&& !sw_flag_wr |=> !sd_q.flag)
		else $error("auto restart did not clear flag");
	a_no_auto_clear: assert property (!restart_q && sd_q.flag && !sw_flag_wr |=> sd_q.flag)
		else $error("flag cleared without firmware");
	a_force_write: assert property (sw_flag_wr && sd_wr[SD_FLAG_BIT] && !sleep_mode
		|=> sd_q.flag ##1 hold_q)
		else $error("forced shutdown not taken");
	a_resume_boundary: assert property ($fell(hold_q) |-> $past(period_start))
		else $error("outputs resumed mid period");
	a_shut_high_ac: assert property (hold_d && !sleep_mode && sd_q.lvl_ac == 2'b01
		&& mode_q[DIR_LO] |=> pwm_out_a && pwm_out_a_oe)
		else $error("pair ac not driven high in shutdown");
	a_shut_tri_bd: assert property (hold_d && !sleep_mode && sd_q.lvl_bd[LVL_TRI_BIT]
		|=> !pwm_out_b_oe && !pwm_out_d_oe)
		else $error("pair bd not released in shutdown");
	a_polarity_ac: assert property (!hold_d && !sleep_mode |=> pwm_out_a == ($past(pwm_raw)
		^ $past(mode_q[POL_AC_BIT])))
		else $error("pair ac polarity wrong");
	a_sleep_freeze: assert property (sleep_mode |=> $stable(timer_q) && $stable(sd_q.flag)
		&& $stable(pwm_out_a))
		else $error("state moved during sleep");
	a_period_flag: assert property (period_start |=> tflag_q)
		else $error("period flag not set");
	a_reset_undriven: assert property (@(posedge clock) disable iff (1'b0) !rst_n
		|=> !pwm_out_a_oe && !pwm_out_b_oe && !pwm_out_c_oe && !pwm_out_d_oe)
		else $error("pins driven after reset");

	c_auto_cycle: cover property (sd_q.flag && restart_q ##[1:50] !sd_q.flag);
	c_fault_shut: cover property ($fell(fault_input_n) && sd_q.src[SRC_FLT_BIT] ##2 hold_q);
	c_resume: cover property ($fell(hold_q));
	c_bad_addr: cover property (pslverr_q);

endmodule : pwmas_top
`default_nettype wire

// File: tb/pwmas_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwmas_bridge_model
(
	// clock
	input wire logic clock,
	// causes asked for by the bench: [0] comp1, [1] comp2, [2] fault
	input wire logic [2:0] cause,
	// pins from the block
	input wire logic [3:0] pin,
	input wire logic [3:0] pin_oe,
	// sense lines and resolved pin wires
	output logic fault_input_n,
	output logic comp1_out,
	output logic comp2_out,
	output logic [3:0] wire_lvl
);
	// sensors change just after an edge, never mid-cycle; settled long before reset ends
	always @(posedge clock)
	begin
		fault_input_n <= ~cause[2];
		comp1_out <= cause[0];
		comp2_out <= cause[1];
	end

	// pull-downs keep released pins low so the switches stay off
	assign wire_lvl = pin & pin_oe;
endmodule : pwmas_bridge_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench
	import pwmas_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] cause = 3'h0;
	logic fault_input_n;
	logic comp1_out;
	logic comp2_out;
	logic sleep_mode = 1'b0;
	logic low_power_run = 1'b0;
	logic low_power_tick = 1'b0;
	logic [3:0] pin;
	logic [3:0] pin_oe;
	logic [3:0] wire_lvl;
	logic [31:0] rdata;
	logic rerr;
	int error_cnt = 0;
	int cmp_count = 0;

	////////////////////////////////////////////////////////////////////////////
	// pin order: [0] a, [1] c, [2] b, [3] d, so each pair is two adjacent bits
	pwmas_top uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fault_input_n(fault_input_n), .comp1_out(comp1_out), .comp2_out(comp2_out),
		.sleep_mode(sleep_mode), .low_power_run(low_power_run), .low_power_tick(low_power_tick),
		.pwm_out_a(pin[0]), .pwm_out_a_oe(pin_oe[0]), .pwm_out_b(pin[2]), .pwm_out_b_oe(pin_oe[2]),
		.pwm_out_c(pin[1]), .pwm_out_c_oe(pin_oe[1]), .pwm_out_d(pin[3]), .pwm_out_d_oe(pin_oe[3]));
	pwmas_bridge_model far (.clock(clock), .cause(cause), .pin(pin), .pin_oe(pin_oe),
		.fault_input_n(fault_input_n), .comp1_out(comp1_out), .comp2_out(comp2_out),
		.wire_lvl(wire_lvl));

	// 25 ns clock
	initial
	begin
		forever #12.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	// one apb transfer; holds everything until pready is seen at an edge
	// no count of its own: only the watchdog cuts a slave that never answers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK("oe", 4'h0, pin_oe)
		rd(ADDR_SHUTDOWN);
		`CHK("sdctl", 32'h0000_0000, rdata)
		rd(ADDR_PERIOD);
		`CHK("period", 32'h0000_00FF, rdata)
		rd(8'h40);
		`CHK("slverr", 1'b1, rerr)
		`CHK("rd_unmapped", 32'h0000_0000, rdata)
	endtask : t_reset

	// firmware bring-up order; period 8 clocks, duty 0 keeps raw pwm low
	task automatic t_setup();
		int n;
		wr(ADDR_MODE, 32'h0000_0000);
		wr(ADDR_PERIOD, 32'h0000_0007);
		wr(ADDR_SHUTDOWN, 32'h0000_0000);
		wr(ADDR_MODE, 32'h0000_000C);
		wr(ADDR_DUTY, 32'h0000_0000);
		wr(ADDR_SHUTDOWN, 32'h0000_0080);
		wr(ADDR_RESTART, 32'h0000_0000);
		wr(ADDR_STATUS, 32'h0000_0001);
		wr(ADDR_MODE, 32'h0000_004C);
		n = 0;
		do
		begin
			rd(ADDR_STATUS);
			n++;
		end
		while (rdata[0] !== 1'b1 && n < 10);
		`CHK("tflag", 1'b1, rdata[0])
		wr(ADDR_MODE, 32'h0000_0F4C);
		wr(ADDR_SHUTDOWN, 32'h0000_0000);
		cyc(12);
		`CHK("oe_on", 4'hF, pin_oe)
		`CHK("pins_run", 4'h0, wire_lvl)
	endtask : t_setup

	// fault pin with each shutdown level, latched flag without restart
	task automatic t_levels();
		logic [1:0] lv;
		logic [1:0] bd;
		for (int i = 0; i < 4; i++)
		begin
			lv = i[1:0];
			bd = ~lv;
			wr(ADDR_SHUTDOWN, {24'h0, 4'h4, lv, bd});
			cause <= 3'h4;
			cyc(4);
			`CHK("oe_lvl", {{2{~bd[1]}}, {2{~lv[1]}}}, pin_oe)
			`CHK("pin_lvl", {{2{~bd[1] & bd[0]}}, {2{~lv[1] & lv[0]}}}, wire_lvl)
			rd(ADDR_SHUTDOWN);
			`CHK("flag_set", 1'b1, rdata[7])
			wr(ADDR_SHUTDOWN, {24'h0, 4'h4, lv, bd});
			rd(ADDR_SHUTDOWN);
			`CHK("flag_busy", 1'b1, rdata[7])
			cause <= 3'h0;
			cyc(3);
			rd(ADDR_SHUTDOWN);
			`CHK("flag_latch", 1'b1, rdata[7])
			wr(ADDR_SHUTDOWN, {24'h0, 4'h4, lv, bd});
			rd(ADDR_SHUTDOWN);
			`CHK("flag_clr", 1'b0, rdata[7])
		end
	endtask : t_levels

	// every source code against every single cause
	task automatic t_sources();
		logic [2:0] s;
		for (int i = 0; i < 8; i++)
		begin
			for (int k = 0; k < 3; k++)
			begin
				s = i[2:0];
				wr(ADDR_SHUTDOWN, {24'h0, 1'b0, s, 4'h0});
				cause <= 3'h1 << k;
				cyc(3);
				rd(ADDR_SHUTDOWN);
				`CHK("src_flag", s[k], rdata[7])
				cause <= 3'h0;
				cyc(3);
				wr(ADDR_SHUTDOWN, {24'h0, 1'b0, s, 4'h0});
			end
		end
	endtask : t_sources

	// comparator level with auto-restart, restart waits for the period edge
	task automatic t_restart();
		int n;
		wr(ADDR_RESTART, 32'h0000_0080);
		wr(ADDR_SHUTDOWN, 32'h0000_0015);
		cause <= 3'h1;
		cyc(4);
		`CHK("sd_high", 4'hF, wire_lvl)
		cyc(10);
		wr(ADDR_SHUTDOWN, 32'h0000_0015);
		rd(ADDR_SHUTDOWN);
		`CHK("flag_level", 1'b1, rdata[7])
		cause <= 3'h0;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (wire_lvl !== 4'h0 && n < 40);
		`CHK("resume_wait", 1'b1, n >= 4 && n <= 11)
		// pins came back on the wrap, so the timer stands three ticks past zero
		rd(ADDR_STATUS);
		`CHK("resume_phase", 8'h03, rdata[15:8])
		rd(ADDR_SHUTDOWN);
		`CHK("flag_auto", 1'b0, rdata[7])
		wr(ADDR_RESTART, 32'h0000_0000);
	endtask : t_restart

	// software-forced shutdown
	task automatic t_force();
		wr(ADDR_SHUTDOWN, 32'h0000_0085);
		cyc(3);
		`CHK("force_pins", 4'hF, wire_lvl)
		rd(ADDR_SHUTDOWN);
		`CHK("force_flag", 1'b1, rdata[7])
		wr(ADDR_SHUTDOWN, 32'h0000_0005);
		cyc(12);
		`CHK("force_end", 4'h0, wire_lvl)
	endtask : t_force

	// polarity changed only with the pins released
	task automatic t_polarity();
		wr(ADDR_MODE, 32'h0000_004E);
		wr(ADDR_MODE, 32'h0000_0F4E);
		cyc(12);
		`CHK("pol_ac", 4'h3, wire_lvl)
		wr(ADDR_MODE, 32'h0000_004D);
		wr(ADDR_MODE, 32'h0000_0F4D);
		cyc(12);
		`CHK("pol_bd", 4'hC, wire_lvl)
		wr(ADDR_MODE, 32'h0000_004C);
		wr(ADDR_MODE, 32'h0000_0F4C);
	endtask : t_polarity

	// sleep freezes; low-power run ticks only on the slow pulse
	task automatic t_power();
		logic [7:0] t1;
		sleep_mode <= 1'b1;
		cyc(1);
		rd(ADDR_STATUS);
		t1 = rdata[15:8];
		cyc(6);
		rd(ADDR_STATUS);
		`CHK("sleep_tmr", t1, rdata[15:8])
		sleep_mode <= 1'b0;
		low_power_run <= 1'b1;
		wr(ADDR_STATUS, 32'h0000_0001);
		rd(ADDR_STATUS);
		`CHK("tflag_clr", 1'b0, rdata[0])
		t1 = rdata[15:8];
		rd(ADDR_STATUS);
		`CHK("lp_hold", t1, rdata[15:8])
		repeat (8)
		begin
			@(posedge clock);
			low_power_tick <= 1'b1;
			@(posedge clock);
			low_power_tick <= 1'b0;
		end
		rd(ADDR_STATUS);
		`CHK("lp_wrap", 1'b1, rdata[0])
		`CHK("lp_tmr", t1, rdata[15:8])
		low_power_run <= 1'b0;
	endtask : t_power

	// divide-by-4 and divide-by-16 codes: reads sit 16 clocks apart
	task automatic t_prescale();
		logic [7:0] t1;
		wr(ADDR_MODE, 32'h0000_0F5C);
		rd(ADDR_STATUS);
		t1 = rdata[15:8];
		cyc(12);
		rd(ADDR_STATUS);
		`CHK("pre_div4", 8'h04, (rdata[15:8] - t1) & 8'h07)
		wr(ADDR_MODE, 32'h0000_0F6C);
		rd(ADDR_STATUS);
		t1 = rdata[15:8];
		cyc(12);
		rd(ADDR_STATUS);
		`CHK("pre_div16", 8'h01, (rdata[15:8] - t1) & 8'h07)
		wr(ADDR_MODE, 32'h0000_0F4C);
	endtask : t_prescale

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// a hang is cut well past the thousand or so cycles the tests need
	initial
	begin
		repeat (40000) @(posedge clock);
		error_cnt++;
		wrap_up();
	end

	initial
	begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_setup();
		t_levels();
		t_sources();
		t_restart();
		t_force();
		t_polarity();
		t_power();
		t_prescale();
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
